// ==== logic/pbaio_pkg.sv ====
// package: register map, field layout, reset values and bus carriers of the pin data block
package pbaio_pkg;

    // =====================================================================
    // sizes
    // =====================================================================
    localparam int PBAIO_DATA_W   = 32;
    localparam int PBAIO_ADDR_W   = 12;
    localparam int PBAIO_PB_PINS  = 7;
    localparam int PBAIO_AIO_PINS = 6;
    localparam int PBAIO_FUNC_W   = 2;

    // =====================================================================
    // register byte offsets
    // =====================================================================
    localparam logic [PBAIO_ADDR_W-1:0] OFS_PB_DATA  = 12'h000;
    localparam logic [PBAIO_ADDR_W-1:0] OFS_AIO_DATA = 12'h004;
    localparam logic [PBAIO_ADDR_W-1:0] OFS_PB_FUNC  = 12'h008;
    localparam logic [PBAIO_ADDR_W-1:0] OFS_PB_DIR   = 12'h00c;
    localparam logic [PBAIO_ADDR_W-1:0] OFS_AIO_MODE = 12'h010;
    localparam logic [PBAIO_ADDR_W-1:0] OFS_AIO_DIR  = 12'h014;

    // =====================================================================
    // field layout and codes
    // =====================================================================
    localparam logic [PBAIO_DATA_W-1:0] PB_DATA_MASK  = 32'h0000_007f;
    localparam logic [PBAIO_DATA_W-1:0] AIO_IMPL_MASK = 32'h0000_5454;
    localparam logic [PBAIO_FUNC_W-1:0] FUNC_GPIO     = 2'h0;

    // =====================================================================
    // reset values
    // =====================================================================
    localparam logic [PBAIO_PB_PINS*PBAIO_FUNC_W-1:0] RST_PB_FUNC    = 14'h0000;
    localparam logic [PBAIO_PB_PINS-1:0]              RST_PB_DIR     = 7'h00;
    localparam logic [PBAIO_AIO_PINS-1:0]             RST_AIO_ANALOG = 6'h3f;
    localparam logic [PBAIO_AIO_PINS-1:0]             RST_AIO_DIR    = 6'h00;
    localparam logic [PBAIO_DATA_W-1:0]               RST_PRDATA     = 32'h0000_0000;

    // =====================================================================
    // types
    // =====================================================================
    typedef enum logic [2:0] {
        SEL_NONE     = 3'h0,
        SEL_PB_DATA  = 3'h1,
        SEL_AIO_DATA = 3'h3,
        SEL_PB_FUNC  = 3'h2,
        SEL_PB_DIR   = 3'h6,
        SEL_AIO_MODE = 3'h7,
        SEL_AIO_DIR  = 3'h5
    } pbaio_sel_e;

    typedef struct packed {
        logic                    psel;
        logic                    penable;
        logic                    pwrite;
        logic [PBAIO_ADDR_W-1:0] paddr;
        logic [PBAIO_DATA_W-1:0] pwdata;
    } pbaio_apb_req_s;

    typedef struct packed {
        logic [PBAIO_PB_PINS*PBAIO_FUNC_W-1:0] pb_func;
        logic [PBAIO_PB_PINS-1:0]              pb_dir;
        logic [PBAIO_AIO_PINS-1:0]             aio_analog;
        logic [PBAIO_AIO_PINS-1:0]             aio_dir;
        logic [PBAIO_DATA_W-1:0]               prdata;
        logic                                  pslverr;
    } pbaio_regs_s;

    // =====================================================================
    // functions
    // =====================================================================
    function automatic pbaio_sel_e pbaio_decode(input logic [PBAIO_ADDR_W-1:0] addr);
        pbaio_sel_e sel;
        sel = SEL_NONE;
        if (addr == OFS_PB_DATA) begin
            sel = SEL_PB_DATA;
        end else if (addr == OFS_AIO_DATA) begin
            sel = SEL_AIO_DATA;
        end else if (addr == OFS_PB_FUNC) begin
            sel = SEL_PB_FUNC;
        end else if (addr == OFS_PB_DIR) begin
            sel = SEL_PB_DIR;
        end else if (addr == OFS_AIO_MODE) begin
            sel = SEL_AIO_MODE;
        end else if (addr == OFS_AIO_DIR) begin
            sel = SEL_AIO_DIR;
        end
        return sel;
    endfunction : pbaio_decode

    // gathers the sparse analog bits of a register word into a dense vector
    function automatic logic [PBAIO_AIO_PINS-1:0] pbaio_aio_pack(
        input logic [PBAIO_DATA_W-1:0] word);
        logic [PBAIO_AIO_PINS-1:0] v;
        int                        j;
        v = '0;
        j = 0;
        for (int i = 0; i < PBAIO_DATA_W; i++) begin
            if (AIO_IMPL_MASK[i]) begin
                v[j] = word[i];
                j++;
            end
        end
        return v;
    endfunction : pbaio_aio_pack

    // spreads a dense analog vector onto its sparse register positions
    function automatic logic [PBAIO_DATA_W-1:0] pbaio_aio_unpack(
        input logic [PBAIO_AIO_PINS-1:0] v);
        logic [PBAIO_DATA_W-1:0] word;
        int                      j;
        word = '0;
        j = 0;
        for (int i = 0; i < PBAIO_DATA_W; i++) begin
            if (AIO_IMPL_MASK[i]) begin
                word[i] = v[j];
                j++;
            end
        end
        return word;
    endfunction : pbaio_aio_unpack

endpackage : pbaio_pkg

// ==== logic/pbaio_pin_bank.sv ====
// module: output latches, drive gating and sampled pin levels for one group of pins
`timescale 1ns/10ps
module pbaio_pin_bank import pbaio_pkg::*; #(
    parameter int W = 7
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // latch load
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    // per-pin drive permission
    input  wire logic [W-1:0] drive_en,
    // pins
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe,
    // sampled level for reads
    output logic      [W-1:0] level
);

    // =====================================================================
    // state
    // =====================================================================
    typedef struct packed {
        logic [W-1:0] latch;
        logic [W-1:0] level;
    } pbaio_bank_s;

    pbaio_bank_s st_q;
    pbaio_bank_s st_d;

    always_comb begin
        st_d       = st_q;
        st_d.level = pin_in;                         // [RL5] [RL9]
        if (wr_en) begin
            st_d.latch = wr_data;                    // [RL4] [RL10]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;                              // [RL11]
        end else begin
            st_q <= st_d;
        end
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign pin_out = st_q.latch;
    assign pin_oe  = drive_en;                       // [RL3] [RL8]
    assign level   = st_q.level;

endmodule : pbaio_pin_bank

// ==== logic/pbaio_data_regs.sv ====
// module: apb register file for port b and analog pin data with pin drive gating
// Summary of operation
// [RL1] port b data holds one bit per pin in bits 6..0 and bits 31..7 read zero.
// [RL2] reading a port b data bit returns the pin level whatever its function or direction.
// [RL3] a port b pin is driven from its latch only when it is a general-purpose output.
// [RL4] a write to a pin that is not a general-purpose output still loads the latch.
// [RL5] data reads after reset follow whatever level each pin presents.
// [RL6] analog data implements bits 14, 12, 10, 6, 4 and 2 only; the rest read zero.
// [RL7] reading an analog data bit returns the pin level regardless of its setup.
// [RL8] an analog pin is driven only when set up as a digital output; else only latched.
// [RL9] data reads show the sampled pin level, never the latch contents.
// [RL10] an output latch keeps its value until it is written again.
// [RL11] reset clears every output latch to zero.
// [RL12] writes to reserved positions are dropped and keep reading zero, except analog mode and direction, which read back packed into bits 5..0.
`timescale 1ns/10ps
module pbaio_data_regs import pbaio_pkg::*; (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire pbaio_apb_req_s              apb_req,
    output logic                             pready,
    output logic      [PBAIO_DATA_W-1:0]     prdata,
    output logic                             pslverr,
    // port b pins
    input  wire logic [PBAIO_PB_PINS-1:0]    pb_pin_in,
    output logic      [PBAIO_PB_PINS-1:0]    pb_pin_out,
    output logic      [PBAIO_PB_PINS-1:0]    pb_pin_oe,
    // analog pins used as digital lines
    input  wire logic [PBAIO_AIO_PINS-1:0]   aio_pin_in,
    output logic      [PBAIO_AIO_PINS-1:0]   aio_pin_out,
    output logic      [PBAIO_AIO_PINS-1:0]   aio_pin_oe
);

    // =====================================================================
    // bus phases
    // =====================================================================
    pbaio_regs_s               st_q;
    pbaio_regs_s               st_d;
    pbaio_sel_e                sel;
    logic                      setup;
    logic                      wr_take;
    logic                      pb_wr;
    logic                      aio_wr;
    logic [PBAIO_PB_PINS-1:0]  pb_drive;
    logic [PBAIO_AIO_PINS-1:0] aio_drive;
    logic [PBAIO_PB_PINS-1:0]  pb_lvl;
    logic [PBAIO_AIO_PINS-1:0] aio_lvl;

    assign sel     = pbaio_decode(apb_req.paddr);
    assign setup   = apb_req.psel && !apb_req.penable;
    assign wr_take = apb_req.psel && apb_req.penable && apb_req.pwrite && pready;
    assign pb_wr   = wr_take && (sel == SEL_PB_DATA);
    assign aio_wr  = wr_take && (sel == SEL_AIO_DATA);
    assign pready  = 1'b1;

    // =====================================================================
    // register file
    // =====================================================================
    always_comb begin
        st_d = st_q;
        if (setup) begin
            st_d.pslverr = (sel == SEL_NONE);
            st_d.prdata  = RST_PRDATA;
            if (!apb_req.pwrite) begin
                case (sel)
                    SEL_PB_DATA:  st_d.prdata = 32'(pb_lvl) & PB_DATA_MASK;   // [RL1] [RL2] [RL9]
                    SEL_AIO_DATA: st_d.prdata = pbaio_aio_unpack(aio_lvl);    // [RL6] [RL7] [RL9]
                    SEL_PB_FUNC:  st_d.prdata = 32'(st_q.pb_func);
                    SEL_PB_DIR:   st_d.prdata = 32'(st_q.pb_dir);
                    SEL_AIO_MODE: st_d.prdata = 32'(st_q.aio_analog);
                    SEL_AIO_DIR:  st_d.prdata = 32'(st_q.aio_dir);
                    default:      st_d.prdata = RST_PRDATA;
                endcase
            end
        end
        if (wr_take) begin
            case (sel)
                SEL_PB_FUNC:  st_d.pb_func    = apb_req.pwdata[PBAIO_PB_PINS*PBAIO_FUNC_W-1:0];
                SEL_PB_DIR:   st_d.pb_dir     = apb_req.pwdata[PBAIO_PB_PINS-1:0];
                SEL_AIO_MODE: st_d.aio_analog = pbaio_aio_pack(apb_req.pwdata);
                SEL_AIO_DIR:  st_d.aio_dir    = pbaio_aio_pack(apb_req.pwdata);
                default:      st_d.pb_dir     = st_q.pb_dir;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.pb_func    <= RST_PB_FUNC;
            st_q.pb_dir     <= RST_PB_DIR;
            st_q.aio_analog <= RST_AIO_ANALOG;
            st_q.aio_dir    <= RST_AIO_DIR;
            st_q.prdata     <= RST_PRDATA;
            st_q.pslverr    <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata  = st_q.prdata;
    assign pslverr = st_q.pslverr;

    // =====================================================================
    // drive permission
    // =====================================================================
    for (genvar i = 0; i < PBAIO_PB_PINS; i++) begin : g_pb_drive
        assign pb_drive[i] = st_q.pb_dir[i]
            && (st_q.pb_func[i*PBAIO_FUNC_W +: PBAIO_FUNC_W] == FUNC_GPIO);  // [RL3]
    end

    assign aio_drive = st_q.aio_dir & ~st_q.aio_analog;                      // [RL8]

    // =====================================================================
    // pin banks
    // =====================================================================
    pbaio_pin_bank #(
        .W        (PBAIO_PB_PINS)
    ) u_pb_bank (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr_en    (pb_wr),
        .wr_data  (apb_req.pwdata[PBAIO_PB_PINS-1:0]),                       // [RL12]
        .drive_en (pb_drive),
        .pin_in   (pb_pin_in),
        .pin_out  (pb_pin_out),
        .pin_oe   (pb_pin_oe),
        .level    (pb_lvl)
    );

    pbaio_pin_bank #(
        .W        (PBAIO_AIO_PINS)
    ) u_aio_bank (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr_en    (aio_wr),
        .wr_data  (pbaio_aio_pack(apb_req.pwdata)),                          // [RL12]
        .drive_en (aio_drive),
        .pin_in   (aio_pin_in),
        .pin_out  (aio_pin_out),
        .pin_oe   (aio_pin_oe),
        .level    (aio_lvl)
    );

    // =====================================================================
    // assertions
    // =====================================================================
    logic rd_pb;
    logic rd_aio;

    assign rd_pb  = setup && !apb_req.pwrite && (sel == SEL_PB_DATA);
    assign rd_aio = setup && !apb_req.pwrite && (sel == SEL_AIO_DATA);

    logic                     cfg_wr;
    logic [PBAIO_PB_PINS-1:0] pb_gpio;

    assign cfg_wr = wr_take && (sel != SEL_PB_DATA) && (sel != SEL_AIO_DATA);
    for (genvar i = 0; i < PBAIO_PB_PINS; i++) begin : g_pb_gpio
        assign pb_gpio[i] = (st_q.pb_func[i*PBAIO_FUNC_W +: PBAIO_FUNC_W] == FUNC_GPIO);
    end

    a_pb_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
        rd_pb |=> (prdata & ~PB_DATA_MASK) == '0)
        else $error("port b data read shows nonzero reserved bits");

    a_pb_read_level: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
        rd_pb |=> prdata[PBAIO_PB_PINS-1:0] == $past(pb_pin_in, 2))
        else $error("port b data read does not match pin level");

    a_pb_drive_gate: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
        (pb_pin_oe & ~st_q.pb_dir) == '0)
        else $error("port b pin driven while set as input");

    a_pb_write_latch: assert property (@(posedge pclk) disable iff (!presetn) // [RL4]
        pb_wr |=> pb_pin_out == $past(apb_req.pwdata[PBAIO_PB_PINS-1:0]))
        else $error("port b latch did not take written value");

    a_level_follow: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
        presetn && $past(presetn)
            |-> (pb_lvl == $past(pb_pin_in)) && (aio_lvl == $past(aio_pin_in)))
        else $error("sampled level does not follow the pins");

    a_aio_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RL6]
        rd_aio |=> (prdata & ~AIO_IMPL_MASK) == '0)
        else $error("analog data read shows nonzero reserved bits");

    a_aio_read_level: assert property (@(posedge pclk) disable iff (!presetn) // [RL7]
        rd_aio |=> pbaio_aio_pack(prdata) == $past(aio_pin_in, 2))
        else $error("analog data read does not match pin level");

    a_aio_drive_gate: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
        (aio_pin_oe & (st_q.aio_analog | ~st_q.aio_dir)) == '0)
        else $error("analog pin driven while not a digital output");

    a_read_not_latch: assert property (@(posedge pclk) disable iff (!presetn) // [RL9]
        rd_pb && (pb_pin_out != pb_lvl) |=> prdata[PBAIO_PB_PINS-1:0] != $past(pb_pin_out))
        else $error("data read returned latch instead of pin level");

    a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RL10]
        !pb_wr && !aio_wr |=> $stable(pb_pin_out) && $stable(aio_pin_out))
        else $error("output latch changed without a write");

    a_reset_clear: assert property (@(posedge pclk)                        // [RL11]
        !presetn |-> pb_pin_out == '0 && aio_pin_out == '0)
        else $error("output latch not cleared by reset");

    a_rsvd_write: assert property (@(posedge pclk) disable iff (!presetn) // [RL12]
        aio_wr |=> aio_pin_out == pbaio_aio_pack($past(apb_req.pwdata)))
        else $error("analog latch took a reserved bit");

    // =====================================================================
    // assertions: drive, latch, sampled level and bus response
    // =====================================================================
    a_pb_oe_on: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
        (pb_drive & ~pb_pin_oe) == '0)
        else $error("port b output pin left undriven");

    a_pb_func_gate: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
        (pb_pin_oe & ~pb_gpio) == '0)
        else $error("port b pin driven while given to a peripheral");

    a_aio_oe_on: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
        (aio_drive & ~aio_pin_oe) == '0)
        else $error("analog output pin left undriven");

    a_pb_latch_only: assert property (@(posedge pclk) disable iff (!presetn) // [RL4]
        pb_wr && (pb_drive == '0) |=> pb_pin_oe == '0)
        else $error("port b data write started driving a pin");

    a_pb_write_undriven: assert property (@(posedge pclk) disable iff (!presetn) // [RL4]
        pb_wr && (pb_drive == '0) |=> pb_pin_out == $past(apb_req.pwdata[PBAIO_PB_PINS-1:0]))
        else $error("port b latch missed a write while undriven");

    a_aio_write_latch: assert property (@(posedge pclk) disable iff (!presetn) // [RL4]
        aio_wr && (aio_drive == '0) |=> aio_pin_out == $past(pbaio_aio_pack(apb_req.pwdata)))
        else $error("analog latch missed a write while undriven");

    a_aio_latch_only: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
        aio_wr && (aio_drive == '0) |=> aio_pin_oe == '0)
        else $error("analog data write started driving a pin");

    a_pb_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RL10]
        !pb_wr |=> $stable(pb_pin_out))
        else $error("port b latch changed without a write");

    a_aio_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RL10]
        !aio_wr |=> $stable(aio_pin_out))
        else $error("analog latch changed without a write");

    a_cfg_wr_latch: assert property (@(posedge pclk) disable iff (!presetn) // [RL10]
        cfg_wr |=> $stable(pb_pin_out) && $stable(aio_pin_out))
        else $error("config write disturbed an output latch");

    a_pb_wr_only: assert property (@(posedge pclk) disable iff (!presetn) // [RL12]
        pb_wr |=> $stable(aio_pin_out))
        else $error("port b write reached the analog latch");

    a_aio_wr_only: assert property (@(posedge pclk) disable iff (!presetn) // [RL12]
        aio_wr |=> $stable(pb_pin_out))
        else $error("analog write reached the port b latch");

    a_pb_read_ok: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
        rd_pb |=> !pslverr)
        else $error("port b data read flagged an error");

    a_aio_read_ok: assert property (@(posedge pclk) disable iff (!presetn) // [RL6]
        rd_aio |=> !pslverr)
        else $error("analog data read flagged an error");

    a_aio_not_latch: assert property (@(posedge pclk) disable iff (!presetn) // [RL9]
        rd_aio && (aio_pin_out != aio_lvl) |=> pbaio_aio_pack(prdata) != $past(aio_pin_out))
        else $error("analog read returned latch instead of pin level");

    a_read_stands: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
        apb_req.psel && apb_req.penable |=> $stable(prdata))
        else $error("read data changed in the access cycle");

    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn) // [RL12]
        setup && (sel == SEL_NONE) |=> pslverr && (prdata == '0))
        else $error("unmapped access not refused");

    a_reset_no_drive: assert property (@(posedge pclk) // [RL11]
        !presetn |-> (pb_pin_oe == '0) && (aio_pin_oe == '0))
        else $error("pin driven during reset");

    a_lvl_reset: assert property (@(posedge pclk) // [RL5]
        !presetn |-> (pb_lvl == '0) && (aio_lvl == '0))
        else $error("sampled levels not cleared during reset");

    c_pb_write: cover property (@(posedge pclk) disable iff (!presetn)
        pb_wr && (pb_drive != '0));

    c_aio_read: cover property (@(posedge pclk) disable iff (!presetn)
        rd_aio ##1 (prdata != '0));

    c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
        setup && (sel == SEL_NONE) ##1 pslverr);

    c_latched_only: cover property (@(posedge pclk) disable iff (!presetn)
        aio_wr && (aio_drive == '0));

    c_pb_driven_read: cover property (@(posedge pclk) disable iff (!presetn)
        rd_pb && (pb_pin_oe != '0));

endmodule : pbaio_data_regs

// ==== test/pbaio_pin_model.sv ====
// board side of the pins: resolves each pin from the block's drive or the board's own level
`timescale 1ns/10ps
module pbaio_pin_model import pbaio_pkg::*; (
    // block side
    input  wire logic [PBAIO_PB_PINS-1:0]  pb_pin_out,
    input  wire logic [PBAIO_PB_PINS-1:0]  pb_pin_oe,
    input  wire logic [PBAIO_AIO_PINS-1:0] aio_pin_out,
    input  wire logic [PBAIO_AIO_PINS-1:0] aio_pin_oe,
    // board drivers
    input  wire logic [PBAIO_PB_PINS-1:0]  pb_board,
    input  wire logic [PBAIO_AIO_PINS-1:0] aio_board,
    // resolved levels
    output logic      [PBAIO_PB_PINS-1:0]  pb_pin_in,
    output logic      [PBAIO_AIO_PINS-1:0] aio_pin_in
);
    // =====================================================================
    // a driven pin shows the block's level, an undriven one the board's
    // =====================================================================
    assign pb_pin_in  = (pb_pin_oe & pb_pin_out) | (~pb_pin_oe & pb_board);
    assign aio_pin_in = (aio_pin_oe & aio_pin_out) | (~aio_pin_oe & aio_board);
endmodule : pbaio_pin_model

// ==== test/pbaio_data_regs_tb.sv ====
// self-checking bench for the port b and analog pin data registers
`timescale 1ns/10ps
module pbaio_data_regs_tb import pbaio_pkg::*;;
    logic                      pclk;
    logic                      presetn;
    pbaio_apb_req_s            req;
    logic                      pready;
    logic [PBAIO_DATA_W-1:0]   prdata;
    logic                      pslverr;
    logic [PBAIO_PB_PINS-1:0]  pb_in, pb_out, pb_oe, pb_board;
    logic [PBAIO_AIO_PINS-1:0] aio_in, aio_out, aio_oe, aio_board;
    int                        miscompares;
    int                        n_tests;

    // =====================================================================
    // clock, design and board
    // =====================================================================
    always #5 pclk = ~pclk;

    pbaio_data_regs pbaio_data_regs_i (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .pb_pin_in(pb_in), .pb_pin_out(pb_out),
        .pb_pin_oe(pb_oe), .aio_pin_in(aio_in), .aio_pin_out(aio_out),
        .aio_pin_oe(aio_oe)
    );

    pbaio_pin_model pbaio_pin_model_i (
        .pb_pin_out(pb_out), .pb_pin_oe(pb_oe), .aio_pin_out(aio_out),
        .aio_pin_oe(aio_oe), .pb_board(pb_board), .aio_board(aio_board),
        .pb_pin_in(pb_in), .aio_pin_in(aio_in)
    );

    // =====================================================================
    // helpers
    // =====================================================================
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer, entered just after a rising edge; leaves one idle cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= a;
        req.pwdata  <= wd;
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            miscompares++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check(r, exp);
        check({31'h0, e}, {31'h0, exp_err});
    endtask : rd

    // =====================================================================
    // main sequence
    // =====================================================================
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        req = '0;
        miscompares = 0;
        n_tests = 0;
        pb_board = 7'h55;
        aio_board = 6'h2a;
        repeat (2) @(posedge pclk);
        check({25'h0, pb_out}, 32'h0000_0000);
        check({26'h0, aio_out}, 32'h0000_0000);
        check({19'h0, pb_oe, aio_oe}, 32'h0000_0000);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(OFS_PB_DATA, 32'h0000_0055, 1'b0);
        rd(OFS_AIO_DATA, 32'h0000_4410, 1'b0);
        // latch loads while undriven; reserved bits dropped
        wr(OFS_PB_DATA, 32'hffff_ff2a);
        check({25'h0, pb_out}, 32'h0000_002a);
        check({25'h0, pb_oe}, 32'h0000_0000);
        rd(OFS_PB_DATA, 32'h0000_0055, 1'b0);
        // low nibble becomes general-purpose output
        wr(OFS_PB_DIR, 32'h0000_000f);
        check({25'h0, pb_oe}, 32'h0000_000f);
        repeat (2) @(posedge pclk);
        rd(OFS_PB_DATA, 32'h0000_005a, 1'b0);
        // a write to driven pins shows on them at once
        wr(OFS_PB_DATA, 32'h0000_0003);
        check({25'h0, pb_out}, 32'h0000_0003);
        rd(OFS_PB_DATA, 32'h0000_0053, 1'b0);
        wr(OFS_PB_DATA, 32'h0000_002a);
        // pin 0 handed to a peripheral function stops being driven
        wr(OFS_PB_FUNC, 32'h0000_0001);
        check({25'h0, pb_oe}, 32'h0000_000e);
        repeat (2) @(posedge pclk);
        rd(OFS_PB_DATA, 32'h0000_005b, 1'b0);
        check({25'h0, pb_out}, 32'h0000_002a);
        // analog pins: latched while blocked, driven once digital outputs
        wr(OFS_AIO_DATA, 32'hffff_ffff);
        check({26'h0, aio_out}, 32'h0000_003f);
        check({26'h0, aio_oe}, 32'h0000_0000);
        rd(OFS_AIO_DATA, 32'h0000_4410, 1'b0);
        wr(OFS_AIO_MODE, 32'h0000_0000);
        check({26'h0, aio_oe}, 32'h0000_0000);
        wr(OFS_AIO_DIR, 32'h0000_5454);
        check({26'h0, aio_oe}, 32'h0000_003f);
        repeat (2) @(posedge pclk);
        rd(OFS_AIO_DATA, 32'h0000_5454, 1'b0);
        wr(OFS_AIO_DATA, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        rd(OFS_AIO_DATA, 32'h0000_0000, 1'b0);
        check({25'h0, pb_out}, 32'h0000_002a);
        // board level change seen through the sampled level
        pb_board <= 7'h2a;
        repeat (2) @(posedge pclk);
        rd(OFS_PB_DATA, 32'h0000_002a, 1'b0);
        // reset in mid-run clears latches and drive; reads follow the board
        presetn <= 1'b0;
        @(posedge pclk);
        check({19'h0, pb_out, aio_out}, 32'h0000_0000);
        check({19'h0, pb_oe, aio_oe}, 32'h0000_0000);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(OFS_PB_DATA, 32'h0000_002a, 1'b0);
        rd(OFS_AIO_DATA, 32'h0000_4410, 1'b0);
        // unmapped address
        rd(12'h040, 32'h0000_0000, 1'b1);
        conclude();
    end
endmodule : pbaio_data_regs_tb
